// >>> design/stn_bus_if.sv
// expansion slot write bus between host and tone card
`timescale 1ns/1ps
`default_nettype none
interface stn_bus_if;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;

    modport host (
        output bus_addr,
        output bus_wdata,
        output bus_wr,
        output bus_rd
    );

    modport card (
        input  bus_addr,
        input  bus_wdata,
        input  bus_wr,
        input  bus_rd
    );
endinterface
`default_nettype wire

// >>> design/stn_card.sv
// tone card end: three stereo positions of tones and noise
`timescale 1ns/1ps
`default_nettype none
`include "stn_consts.svh"
module stn_card #(
    parameter logic [2:0] SLOT     = `STN_SLOT_DFLT,
    parameter int         TICK_CYC = `STN_TICK_CYC
) (
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // host bus
    stn_bus_if.card              bus,
    // audio per stereo position
    output logic [2:0][9:0]      audio,
    output logic [2:0][2:0]      tone_out,
    output logic [2:0]           noise_out,
    output logic [2:0]           mode_set
);

    stn_pkg::stn_card_t st_reg;
    stn_pkg::stn_card_t st_next;

    // level for an attenuation code, two decibel steps
    function automatic logic [7:0] stn_level(input logic [3:0] att);
        case (att)
            4'h0: stn_level = 8'hFF;
            4'h1: stn_level = 8'hCB;
            4'h2: stn_level = 8'hA1;
            4'h3: stn_level = 8'h80;
            4'h4: stn_level = 8'h66;
            4'h5: stn_level = 8'h51;
            4'h6: stn_level = 8'h40;
            4'h7: stn_level = 8'h33;
            4'h8: stn_level = 8'h28;
            4'h9: stn_level = 8'h20;
            4'hA: stn_level = 8'h1A;
            4'hB: stn_level = 8'h14;
            4'hC: stn_level = 8'h10;
            4'hD: stn_level = 8'h0D;
            4'hE: stn_level = 8'h0A;
            default: stn_level = 8'h00;
        endcase
    endfunction

    logic [15:0] base_addr;
    logic        addr_hit;
    logic [1:0]  addr_port;

    assign base_addr = stn_pkg::stn_port_addr(SLOT, 2'h0);
    assign addr_port = bus.bus_addr[1:0];
    assign addr_hit  = (bus.bus_addr[15:2] == base_addr[15:2]) && (addr_port != 2'h3);

    always_comb begin
        logic [7:0] d;
        logic [1:0] ch;
        logic [9:0] sum;
        logic       ch2_rise;
        d        = bus.bus_wdata;
        ch       = d[`STN_CHAN_HI:`STN_CHAN_LO];
        sum      = 10'h000;
        ch2_rise = 1'b0;
        st_next  = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.pre == 9'(TICK_CYC - 1)) begin
            st_next.pre  = 9'h000;
            st_next.tick = 1'b1;
        end else begin
            st_next.pre = 9'(st_reg.pre + 9'h001);
        end
        for (int p = 0; p < `STN_NUM_PORTS; p++) begin
            if (bus.bus_wr && addr_hit && (addr_port == 2'(p))) begin
                if (d[`STN_CMD_BIT]) begin
                    if (d[`STN_VOL_BIT]) begin
                        st_next.port[p].att_new[ch] = d[3:0];
                    end else if (ch == `STN_NOISE_CHAN) begin
                        st_next.port[p].sel      = `STN_NOISE_CHAN;
                        st_next.port[p].mode_set = 1'b1;
                    end else begin
                        st_next.port[p].sel = ch;
                        st_next.port[p].div_new[ch][3:0] = d[3:0];
                    end
                end else if (st_reg.port[p].sel != `STN_NOISE_CHAN) begin
                    st_next.port[p].div_new[st_reg.port[p].sel][9:4] = d[5:0];
                    // divisor complete, none pending
                    st_next.port[p].sel = `STN_NOISE_CHAN;
                end
            end
            if (st_reg.tick) begin
                st_next.port[p].att_act = st_reg.port[p].att_new;
                for (int c = 0; c < 3; c++) begin
                    // half-written divisor stays unused
                    if (st_reg.port[p].sel != 2'(c)) begin
                        st_next.port[p].div_act[c] = st_reg.port[p].div_new[c];
                    end
                    if (st_reg.port[p].cnt[c] >=
                        10'(st_reg.port[p].div_act[c] - 10'h001)) begin
                        st_next.port[p].cnt[c]  = 10'h000;
                        st_next.port[p].tone[c] = ~st_reg.port[p].tone[c];
                    end else begin
                        st_next.port[p].cnt[c] = 10'(st_reg.port[p].cnt[c] + 10'h001);
                    end
                end
                ch2_rise = st_next.port[p].tone[2] & ~st_reg.port[p].tone[2];
                if (ch2_rise) begin
                    st_next.port[p].lfsr = {~(st_reg.port[p].lfsr[0] ^
                                              st_reg.port[p].lfsr[1]),
                                            st_reg.port[p].lfsr[14:1]};
                end
                sum = 10'h000;
                for (int c = 0; c < 3; c++) begin
                    if (st_reg.port[p].tone[c]) begin
                        sum = 10'(sum + {2'b00, stn_level(st_reg.port[p].att_act[c])});
                    end
                end
                if (st_reg.port[p].lfsr[0]) begin
                    sum = 10'(sum + {2'b00, stn_level(st_reg.port[p].att_act[3])});
                end
                st_next.port[p].audio = sum;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    generate
        for (genvar p = 0; p < `STN_NUM_PORTS; p++) begin : g_out
            assign audio[p]     = st_reg.port[p].audio;
            assign tone_out[p]  = st_reg.port[p].tone;
            assign noise_out[p] = st_reg.port[p].lfsr[0];
            assign mode_set[p]  = st_reg.port[p].mode_set;
        end
    endgenerate

endmodule
`default_nettype wire

// >>> design/stn_consts.svh
// constants shared by both ends of the stereo tone generator link
`ifndef STN_CONSTS_SVH
`define STN_CONSTS_SVH

// slot addressing
`define STN_IO_BASE      16'hC080
`define STN_SLOT_DFLT    3'h4
`define STN_NUM_PORTS    3

// command byte fields
`define STN_CMD_BIT      7
`define STN_VOL_BIT      4
`define STN_CHAN_HI      6
`define STN_CHAN_LO      5
`define STN_NOISE_CHAN   2'h3

// host initialisation bytes
`define STN_INIT_MUTE0   8'h9F
`define STN_INIT_MUTE1   8'hBF
`define STN_INIT_MUTE2   8'hDF
`define STN_INIT_MUTE3   8'hFF
`define STN_INIT_MODE    8'hE7
`define STN_INIT_STEPS   3'h5

// timing
`define STN_CLK_HZ       40000000
`define STN_TONE_HZ      63920
`define STN_TICK_CYC     ((`STN_CLK_HZ) / (2 * `STN_TONE_HZ))
`define STN_WR_GAP_CYC   18

// host register offsets and fields
`define STN_REG_CMD      4'h0
`define STN_REG_CTRL     4'h4
`define STN_REG_STATUS   4'h8
`define STN_RESP_OKAY    2'h0
`define STN_RESP_SLVERR  2'h2

`endif

// >>> design/stn_host.sv
// host end: AXI4-Lite command registers driving the card bus
`timescale 1ns/1ps
`default_nettype none
`include "stn_consts.svh"
module stn_host #(
    parameter logic [2:0] SLOT   = `STN_SLOT_DFLT,
    parameter int         GAP    = `STN_WR_GAP_CYC
) (
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // axi write address
    input  wire logic [3:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    // axi write data
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // axi write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // axi read
    input  wire logic [3:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // card bus
    stn_bus_if.host              bus
);

    stn_pkg::stn_host_t st_reg;
    stn_pkg::stn_host_t st_next;
    logic               busy;

    assign busy          = (st_reg.eng != stn_pkg::ENG_IDLE) || st_reg.cmd_pend;
    assign s_axi_awready = !st_reg.aw_done && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_done && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;

    always_comb begin
        logic [7:0] ib;
        ib = `STN_INIT_MUTE0;
        st_next = st_reg;
        st_next.bus_wr = 1'b0;
        if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
        if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_done = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_done = 1'b1;
            st_next.wdata  = s_axi_wdata;
        end
        // register writes once address and data are both in
        if (st_reg.aw_done && st_reg.w_done) begin
            st_next.aw_done = 1'b0;
            st_next.w_done  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = `STN_RESP_OKAY;
            case (st_reg.aw_addr)
                `STN_REG_CMD: begin
                    if (busy || st_reg.wdata[9:8] == 2'h3) begin
                        st_next.bresp = `STN_RESP_SLVERR;
                    end else begin
                        st_next.cmd_pend = 1'b1;
                        st_next.cmd_port = st_reg.wdata[9:8];
                        st_next.cmd_byte = st_reg.wdata[7:0];
                    end
                end
                `STN_REG_CTRL: begin
                    if (busy) begin
                        st_next.bresp = `STN_RESP_SLVERR;
                    end else if (st_reg.wdata[0]) begin
                        st_next.init_run  = 1'b1;
                        st_next.init_done = 1'b0;
                        st_next.init_port = 2'h0;
                        st_next.init_step = 3'h0;
                        st_next.eng       = stn_pkg::ENG_INIT;
                    end
                end
                default: st_next.bresp = `STN_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = `STN_RESP_OKAY;
            case (s_axi_araddr)
                `STN_REG_CMD:    st_next.rdata = {22'h000000, st_reg.cmd_port, st_reg.cmd_byte};
                `STN_REG_CTRL:   st_next.rdata = 32'h00000000;
                `STN_REG_STATUS: st_next.rdata = {30'h00000000, st_reg.init_done, busy};
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = `STN_RESP_SLVERR;
                end
            endcase
        end
        // card write engine
        case (st_reg.eng)
            stn_pkg::ENG_IDLE: begin
                // one byte at a time, in order
                if (st_reg.cmd_pend) begin
                    st_next.cmd_pend  = 1'b0;
                    st_next.bus_addr  = stn_pkg::stn_port_addr(SLOT, st_reg.cmd_port);
                    st_next.bus_wdata = st_reg.cmd_byte;
                    st_next.bus_wr    = 1'b1;
                    st_next.gap       = 8'(GAP - 2);
                    st_next.eng       = stn_pkg::ENG_GAP;
                end
            end
            stn_pkg::ENG_INIT: begin
                case (st_reg.init_step)
                    3'h0:    ib = `STN_INIT_MUTE0;
                    3'h1:    ib = `STN_INIT_MUTE1;
                    3'h2:    ib = `STN_INIT_MUTE2;
                    3'h3:    ib = `STN_INIT_MUTE3;
                    default: ib = `STN_INIT_MODE;
                endcase
                st_next.bus_addr  = stn_pkg::stn_port_addr(SLOT, st_reg.init_port);
                st_next.bus_wdata = ib;
                st_next.bus_wr    = 1'b1;
                st_next.gap       = 8'(GAP - 2);
                st_next.eng       = stn_pkg::ENG_GAP;
                if (st_reg.init_step == 3'(`STN_INIT_STEPS - 1)) begin
                    st_next.init_step = 3'h0;
                    if (st_reg.init_port == 2'(`STN_NUM_PORTS - 1)) begin
                        st_next.init_run  = 1'b0;
                        st_next.init_done = 1'b1;
                    end else begin
                        st_next.init_port = 2'(st_reg.init_port + 2'h1);
                    end
                end else begin
                    st_next.init_step = 3'(st_reg.init_step + 3'h1);
                end
            end
            stn_pkg::ENG_GAP: begin
                if (st_reg.gap == 8'h00) begin
                    st_next.eng = st_reg.init_run ? stn_pkg::ENG_INIT : stn_pkg::ENG_IDLE;
                end else begin
                    st_next.gap = 8'(st_reg.gap - 8'h01);
                end
            end
            default: st_next.eng = stn_pkg::ENG_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign bus.bus_addr  = st_reg.bus_addr;
    assign bus.bus_wdata = st_reg.bus_wdata;
    assign bus.bus_wr    = st_reg.bus_wr;
    assign bus.bus_rd    = 1'b0;

endmodule
`default_nettype wire

// >>> design/stn_pkg.sv
// types shared by both ends of the stereo tone generator link
`default_nettype none
`include "stn_consts.svh"
package stn_pkg;

    typedef struct packed {
        logic [3:0][3:0] att_new;
        logic [3:0][3:0] att_act;
        logic [2:0][9:0] div_new;
        logic [2:0][9:0] div_act;
        logic [2:0][9:0] cnt;
        logic [2:0]      tone;
        logic [14:0]     lfsr;
        logic [1:0]      sel;
        logic            mode_set;
        logic [9:0]      audio;
    } stn_port_t;

    typedef struct packed {
        logic [8:0]            pre;
        logic                  tick;
        stn_port_t [2:0]       port;
    } stn_card_t;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_INIT,
        ENG_GAP
    } stn_eng_t;

    typedef struct packed {
        logic            aw_done;
        logic [3:0]      aw_addr;
        logic            w_done;
        logic [31:0]     wdata;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
        logic            cmd_pend;
        logic [1:0]      cmd_port;
        logic [7:0]      cmd_byte;
        logic            init_run;
        logic            init_done;
        logic [1:0]      init_port;
        logic [2:0]      init_step;
        stn_eng_t        eng;
        logic [7:0]      gap;
        logic [15:0]     bus_addr;
        logic [7:0]      bus_wdata;
        logic            bus_wr;
    } stn_host_t;

    function automatic logic [15:0] stn_port_addr(input logic [2:0] slot,
                                                  input logic [1:0] p);
        stn_port_addr = 16'(`STN_IO_BASE + {9'h000, slot, 4'h0} + {14'h0000, p});
    endfunction

endpackage
`default_nettype wire

// >>> test/stereo_tone_generator_ports_test.sv
// self-checking bench joining the host end and the tone card end
`timescale 1ns/1ps
`default_nettype none
`include "stn_consts.svh"
module stereo_tone_generator_ports_test;
    localparam int TICK = 4;
    logic            aclk;
    logic            aresetn;
    logic [3:0]      awaddr;
    logic            awvalid;
    logic            awready;
    logic [31:0]     wdata;
    logic            wvalid;
    logic            wready;
    logic [1:0]      bresp;
    logic            bvalid;
    logic            bready;
    logic [3:0]      araddr;
    logic            arvalid;
    logic            arready;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            rvalid;
    logic            rready;
    logic [2:0][9:0] audio;
    logic [2:0][2:0] tone_out;
    logic [2:0]      noise_out;
    logic [2:0]      mode_set;
    int              err_count;
    int              compares;

    stn_bus_if stn_bus_if_i ();
    stn_card #(.SLOT(`STN_SLOT_DFLT), .TICK_CYC(TICK)) stn_card_i (.aclk(aclk),
        .aresetn(aresetn), .bus(stn_bus_if_i.card), .audio(audio), .tone_out(tone_out),
        .noise_out(noise_out), .mode_set(mode_set));
    stn_host #(.SLOT(`STN_SLOT_DFLT), .GAP(`STN_WR_GAP_CYC)) stn_host_i (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .bus(stn_bus_if_i.host));
    stn_link_asserts #(.SLOT(`STN_SLOT_DFLT), .GAP(`STN_WR_GAP_CYC)) stn_link_asserts_i (
        .aclk(aclk), .aresetn(aresetn), .bus_addr(stn_bus_if_i.bus_addr),
        .bus_wdata(stn_bus_if_i.bus_wdata), .bus_wr(stn_bus_if_i.bus_wr),
        .bus_rd(stn_bus_if_i.bus_rd));

    always #12.5 aclk = ~aclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: value %0h, wanted %0h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: response %0h, wanted %0h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    // poll status until the masked bits match
    task automatic wait_status(input logic [31:0] m, input logic [31:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        d = ~v;
        while ((d & m) !== v && n < 400) begin
            axi_rd(`STN_REG_STATUS, d, r);
            n++;
        end
        check(d & m, v);
    endtask

    task automatic send(input logic [1:0] p, input logic [7:0] b);
        logic [1:0] r;
        wait_status(32'h1, 32'h0);
        axi_wr(`STN_REG_CMD, {22'h0, p, b}, r);
        check_resp(r, `STN_RESP_OKAY);
    endtask

    // cycles until position 1's channel 0 tone changes
    task automatic flip(output int n);
        logic t;
        n = 0;
        t = tone_out[1][0];
        while (tone_out[1][0] === t && n < 9000) begin
            @(posedge aclk);
            n++;
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        check(32'(audio), 32'h0);
        check(32'(mode_set), 32'h0);
        axi_rd(`STN_REG_STATUS, d, r);
        check(d, 32'h0);
        axi_rd(4'hC, d, r);
        check(d, 32'h0);
        check_resp(r, `STN_RESP_SLVERR);
        axi_wr(4'hC, 32'h0, r);
        check_resp(r, `STN_RESP_SLVERR);
        axi_wr(`STN_REG_STATUS, 32'h0, r);
        check_resp(r, `STN_RESP_SLVERR);
        axi_wr(`STN_REG_CMD, 32'h0000_0390, r);
        check_resp(r, `STN_RESP_SLVERR);
        $display("t_regs finished");
    endtask

    task automatic t_init();
        logic [1:0] r;
        axi_wr(`STN_REG_CTRL, 32'h1, r);
        check_resp(r, `STN_RESP_OKAY);
        axi_wr(`STN_REG_CMD, 32'h0000_0090, r);
        check_resp(r, `STN_RESP_SLVERR);
        wait_status(32'h3, 32'h2);
        check(32'(mode_set), 32'h7);
        repeat (3 * TICK) @(posedge aclk);
        check(32'(audio), 32'h0);
        $display("t_init finished");
    endtask

    task automatic t_tone();
        logic [7:0] vb [3] = '{8'h90, 8'h97, 8'h9E};
        logic [9:0] lv [3] = '{10'h0FF, 10'h033, 10'h00A};
        int         n;
        logic       t0;
        send(2'h1, 8'h85);
        t0 = tone_out[1][0];
        repeat (8 * TICK) @(posedge aclk);
        check(32'(tone_out[1][0]), 32'(t0));
        send(2'h1, 8'h02);
        flip(n);
        flip(n);
        flip(n);
        check(32'(n), 32'(37 * TICK));
        for (int i = 0; i < 3; i++) begin
            send(2'h1, vb[i]);
            flip(n);
            if (tone_out[1][0] !== 1'b1) flip(n);
            repeat (2 * TICK) @(posedge aclk);
            check(32'(audio[1]), 32'(lv[i]));
            check(32'(audio[0]), 32'h0);
            check(32'(audio[2]), 32'h0);
        end
        $display("t_tone finished");
    endtask

    task automatic t_noise();
        int   seen;
        int   bad;
        int   flips;
        logic last;
        seen = 0;
        bad = 0;
        flips = 0;
        send(2'h2, 8'hC1);
        send(2'h2, 8'h00);
        send(2'h2, 8'hF0);
        repeat (4 * TICK) @(posedge aclk);
        last = noise_out[2];
        repeat (400) begin
            @(posedge aclk);
            if (audio[2] === 10'h0FF) seen++;
            else if (audio[2] !== 10'h000) bad++;
            if (noise_out[2] !== last) flips++;
            last = noise_out[2];
        end
        check(32'(bad), 32'h0);
        check(32'(seen > 0), 32'h1);
        check(32'(flips > 0), 32'h1);
        $display("t_noise finished");
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = 4'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 4'h0;
        arvalid = 1'b0;
        rready = 1'b0;
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_init();
        t_tone();
        t_noise();
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        $display("unexpected at %0t: watchdog ran out", $time);
        end_sim();
    end
endmodule
`default_nettype wire

// >>> test/stn_link_asserts.sv
// assertions on the card bus between the host end and the tone card end
`timescale 1ns/1ps
`default_nettype none
`include "stn_consts.svh"
module stn_link_asserts #(
    parameter logic [2:0] SLOT = `STN_SLOT_DFLT,
    parameter int         GAP  = `STN_WR_GAP_CYC
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // card bus
    input wire logic [15:0] bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [15:0] base;
    logic [7:0]  since_reg;
    logic [7:0]  last_byte_reg;
    logic [15:0] last_addr_reg;

    assign base = 16'(`STN_IO_BASE + {9'h000, SLOT, 4'h0});

    // cycles since the last strobe, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_reg     <= 8'hFF;
            last_byte_reg <= 8'h00;
            last_addr_reg <= 16'h0000;
        end else if (bus_wr) begin
            since_reg     <= 8'h01;
            last_byte_reg <= bus_wdata;
            last_addr_reg <= bus_addr;
        end else if (since_reg != 8'hFF) begin
            since_reg <= since_reg + 8'h01;
        end
    end

    a_strobe_one_cycle: assert property (bus_wr |=> !bus_wr)
        else $error("card bus strobe held longer than one cycle");
    a_strobe_gap_min: assert property (bus_wr |-> int'(since_reg) >= GAP)
        else $error("card bus strobes closer than the minimum gap");
    a_read_never: assert property (!bus_rd)
        else $error("read strobe raised on the card bus");
    a_addr_in_slot: assert property (bus_wr |-> bus_addr >= base && bus_addr <= base + 16'h0002)
        else $error("card bus write outside the three position ports");
    a_bus_held: assert property (!bus_wr |-> $stable(bus_addr) && $stable(bus_wdata))
        else $error("card bus address or data moved without a strobe");
    a_pair_order: assert property (bus_wr && !bus_wdata[7] |-> last_byte_reg[7]
        && !last_byte_reg[4] && last_byte_reg[6:5] != 2'h3 && bus_addr == last_addr_reg)
        else $error("divisor data byte without a preceding frequency byte");
    a_mute_chain: assert property (bus_wr && bus_wdata inside {8'h9F, 8'hBF, 8'hDF, 8'hFF}
        |-> ##18 bus_wr && bus_addr == $past(bus_addr, 18) && bus_wdata ==
        (($past(bus_wdata, 18) == 8'hFF) ? 8'hE7 : $past(bus_wdata, 18) + 8'h20))
        else $error("initialisation byte out of order");
    a_port_advance: assert property (bus_wr && bus_wdata == 8'hE7 && bus_addr != base + 16'h0002
        |-> ##18 bus_wr && bus_wdata == 8'h9F && bus_addr == $past(bus_addr, 18) + 16'h0001)
        else $error("initialisation skipped a stereo position");
endmodule
`default_nettype wire
